// *** logic/pebt_host.sv ***
// host controller driving an asynchronous byte-wide eeprom through its pins
// assumes the user holds a command until accepted; one clock, all outputs registered
`timescale 1ns/1ps
module pebt_host
#(
    parameter int WRITE_WAIT_CYC = pebt_pkg::WRITE_TIME_CYC, // max write time
    parameter bit USE_POLL = 1'b1 // end write by toggle polling
) (
    input wire logic core_clk_in, // core clock 200 MHz
    input wire logic sys_rst_in, // async reset, high
    input wire logic cmd_valid_in, // command request
    input wire logic cmd_write_in, // 1 write byte, 0 read
    input wire logic cmd_last_in, // last byte of a page
    input wire logic [pebt_pkg::ADDR_W-1:0] cmd_addr_in, // byte address
    input wire logic [pebt_pkg::DATA_W-1:0] cmd_wdata_in, // write data
    output logic cmd_ready_out, // command accepted this cycle
    output logic rd_valid_out, // read data pulse
    output logic [pebt_pkg::DATA_W-1:0] rd_data_out, // read data
    output logic busy_out, // internal write in progress
    output logic page_err_out, // page select bits changed, byte dropped
    output logic [pebt_pkg::ADDR_W-1:0] mem_addr_out, // address pins
    output logic mem_chip_sel_n_out, // chip enable, low active
    output logic mem_out_en_n_out, // output enable, low active
    output logic mem_wr_en_n_out, // write enable, low active
    output logic [pebt_pkg::DATA_W-1:0] mem_dq_out, // data pins out
    output logic mem_dq_oe_n_out, // data pin drive enable, low drives
    input wire logic [pebt_pkg::DATA_W-1:0] mem_dq_in // data pins in
);
    import pebt_pkg::*;
    // read wait covers the slowest access time plus the two sync stages
    localparam int RD_WAIT_CYC = READ_CYC + 2;
    // refuse waits that the saturating age counter cannot reach
    if (WRITE_WAIT_CYC < 1 || WRITE_WAIT_CYC + LOAD_MAX_CYC >= (1 << CNT_W)) begin : g_bad_wait
        $error("write wait count out of range");
    end
    pebt_tmr_if tm ();
    pebt_timer u_tmr (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .t(tm)
    );
    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n);
    endfunction
    pebt_state_t st_r, st_nxt;
    logic [DATA_W-1:0] s1_r, s2_r;
    logic in_page_r, in_page_nxt, poll_r, poll_nxt, prev6_r, prev6_nxt;
    logic last_r, last_nxt, pfirst_r, pfirst_nxt;
    logic [CNT_W-1:0] load_age_r, load_age_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] dq_r, dq_nxt, rd_r, rd_nxt;
    logic cs_n_r, cs_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt, dqoe_n_r, dqoe_n_nxt;
    logic rdy_r, rdy_nxt, rdv_r, rdv_nxt, busy_r, busy_nxt, perr_r, perr_nxt;
    // data pins synchronised before use
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= mem_dq_in;
            s2_r <= s1_r;
        end
    end
    // next state of the pin sequencer
    always_comb begin
        st_nxt = st_r;
        in_page_nxt = in_page_r;
        poll_nxt = poll_r;
        prev6_nxt = prev6_r;
        last_nxt = last_r;
        pfirst_nxt = pfirst_r;
        addr_nxt = addr_r;
        dq_nxt = dq_r;
        rd_nxt = rd_r;
        cs_n_nxt = cs_n_r;
        oe_n_nxt = oe_n_r;
        we_n_nxt = we_n_r;
        dqoe_n_nxt = dqoe_n_r;
        rdy_nxt = 1'b0;
        rdv_nxt = 1'b0;
        busy_nxt = busy_r;
        perr_nxt = 1'b0;
        load_age_nxt = (load_age_r == '1) ? load_age_r : load_age_r + 1'b1;
        tm.load = 1'b0;
        tm.value = '0;
        case (st_r)
            PEBT_IDLE: begin
                if (in_page_r && load_age_r >= cyc(LOAD_MIN_CYC + LOAD_MAX_CYC) / 2) begin
                    // close page well inside the longest spacing
                    st_nxt = PEBT_BUSY;
                    in_page_nxt = 1'b0;
                    busy_nxt = 1'b1;
                end else if (cmd_valid_in && !rdy_r && tm.done) begin
                    addr_nxt = cmd_addr_in;
                    cs_n_nxt = 1'b0;
                    if (!cmd_write_in) begin
                        oe_n_nxt = 1'b0; // read: select and oe low, we high
                        dqoe_n_nxt = 1'b1;
                        st_nxt = PEBT_RD;
                        poll_nxt = 1'b0;
                        tm.load = 1'b1;
                        tm.value = cyc(RD_WAIT_CYC);
                    end else if (in_page_r &&
                            cmd_addr_in[ADDR_W-1:PAGE_LO] != addr_r[ADDR_W-1:PAGE_LO]) begin
                        cs_n_nxt = 1'b1;
                        addr_nxt = addr_r;
                        perr_nxt = 1'b1;
                        rdy_nxt = 1'b1;
                    end else if (!in_page_r || load_age_r >= cyc(LOAD_MIN_CYC)) begin
                        we_n_nxt = 1'b0; // we-controlled byte load
                        dq_nxt = cmd_wdata_in;
                        dqoe_n_nxt = 1'b0; // device floated long ago
                        last_nxt = cmd_last_in;
                        st_nxt = PEBT_WLOW;
                        load_age_nxt = '0;
                        tm.load = 1'b1;
                        tm.value = cyc(STROBE_CYC);
                    end else begin
                        cs_n_nxt = 1'b1;
                        addr_nxt = addr_r;
                    end
                end
            end
            PEBT_RD: begin
                if (tm.done) begin
                    // pins sampled after the access time, then two sync stages
                    rd_nxt = s2_r;
                    cs_n_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    st_nxt = PEBT_RFLT;
                    tm.load = 1'b1;
                    tm.value = cyc(FLOAT_CYC);
                end
            end
            PEBT_RFLT: begin
                if (tm.done) begin
                    if (poll_r) begin
                        // polled toggle bit stops flipping when done
                        if (!pfirst_r && rd_r[TOGGLE_BIT] == prev6_r) begin
                            busy_nxt = 1'b0;
                            st_nxt = PEBT_GAP;
                            tm.load = 1'b1;
                            tm.value = cyc(NEXT_WRITE_CYC);
                        end else begin
                            prev6_nxt = rd_r[TOGGLE_BIT];
                            st_nxt = PEBT_BUSY;
                        end
                    end else begin
                        rdv_nxt = 1'b1;
                        rdy_nxt = 1'b1;
                        st_nxt = PEBT_IDLE;
                    end
                end
            end
            PEBT_WLOW: begin
                if (tm.done) begin
                    we_n_nxt = 1'b1;
                    st_nxt = PEBT_WHIGH;
                    tm.load = 1'b1;
                    tm.value = cyc(RECOVER_CYC > HOLD_CYC ? RECOVER_CYC : HOLD_CYC);
                end
            end
            PEBT_WHIGH: begin
                if (tm.done) begin
                    cs_n_nxt = 1'b1;
                    dqoe_n_nxt = 1'b1;
                    rdy_nxt = 1'b1;
                    if (last_r) begin
                        st_nxt = PEBT_BUSY;
                        in_page_nxt = 1'b0;
                        busy_nxt = 1'b1;
                    end else begin
                        in_page_nxt = 1'b1;
                        st_nxt = PEBT_IDLE;
                    end
                end
            end
            PEBT_BUSY: begin
                // no writes issued while device writes
                // timeout from the last load covers the load window and write
                if (load_age_r >= cyc(WRITE_WAIT_CYC + LOAD_MAX_CYC)) begin
                    busy_nxt = 1'b0;
                    st_nxt = PEBT_GAP;
                    tm.load = 1'b1;
                    tm.value = cyc(NEXT_WRITE_CYC);
                end else if (USE_POLL) begin
                    // the first poll of a write only records the toggle level
                    pfirst_nxt = !poll_r;
                    cs_n_nxt = 1'b0; // polling read
                    oe_n_nxt = 1'b0;
                    poll_nxt = 1'b1;
                    st_nxt = PEBT_RD;
                end
            end
            PEBT_GAP: begin
                if (tm.done) begin
                    st_nxt = PEBT_IDLE;
                    poll_nxt = 1'b0;
                end
            end
            default: begin
                st_nxt = PEBT_IDLE;
            end
        endcase
        // polling read loads its own read timer
        if (st_r == PEBT_BUSY && st_nxt == PEBT_RD) begin
            tm.load = 1'b1;
            tm.value = cyc(RD_WAIT_CYC);
        end
    end
    // register all state and pins
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r <= PEBT_IDLE;
            in_page_r <= 1'b0;
            poll_r <= 1'b0;
            prev6_r <= 1'b0;
            last_r <= 1'b0;
            pfirst_r <= 1'b0;
            load_age_r <= '0;
            addr_r <= '0;
            dq_r <= '0;
            rd_r <= '0;
            cs_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            dqoe_n_r <= 1'b1;
            rdy_r <= 1'b0;
            rdv_r <= 1'b0;
            busy_r <= 1'b0;
            perr_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            in_page_r <= in_page_nxt;
            poll_r <= poll_nxt;
            prev6_r <= prev6_nxt;
            last_r <= last_nxt;
            pfirst_r <= pfirst_nxt;
            load_age_r <= load_age_nxt;
            addr_r <= addr_nxt;
            dq_r <= dq_nxt;
            rd_r <= rd_nxt;
            cs_n_r <= cs_n_nxt;
            oe_n_r <= oe_n_nxt;
            we_n_r <= we_n_nxt;
            dqoe_n_r <= dqoe_n_nxt;
            rdy_r <= rdy_nxt;
            rdv_r <= rdv_nxt;
            busy_r <= busy_nxt;
            perr_r <= perr_nxt;
        end
    end
    assign cmd_ready_out = rdy_r;
    assign rd_valid_out = rdv_r;
    assign rd_data_out = rd_r;
    assign busy_out = busy_r;
    assign page_err_out = perr_r;
    assign mem_addr_out = addr_r;
    assign mem_chip_sel_n_out = cs_n_r;
    assign mem_out_en_n_out = oe_n_r;
    assign mem_wr_en_n_out = we_n_r;
    assign mem_dq_out = dq_r;
    assign mem_dq_oe_n_out = dqoe_n_r;
endmodule

// *** logic/pebt_pkg.sv ***
// package for the parallel eeprom host controller: timing figures and states
// assumes a 200 MHz core clock; all times converted to whole cycles here
package pebt_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int PAGE_LO = 6;
    localparam int TOGGLE_BIT = 6;
    localparam int POLL_BIT = 7;
    // read timing, slowest grade by default, ns
    localparam int READ_PERIOD_NS = 120;
    localparam int OUT_DRIVE_FLOAT_NS = 30;
    // write strobe timing, ns
    localparam int STROBE_WIDTH_NS = 50;
    localparam int STROBE_HIGH_RECOVERY_NS = 50;
    localparam int ADDR_HOLD_NS = 50;
    // byte load spacing, ns (min 0.15 us, max 100 us)
    localparam int BYTE_LOAD_MIN_NS = 150;
    localparam int BYTE_LOAD_MAX_NS = 100000;
    // delay to next write, ns
    localparam int NEXT_WRITE_DELAY_NS = 10000;
    // internal write time, us (max)
    localparam int INTERNAL_WRITE_TIME_US = 5000;
    function automatic int ns_up(input int ns);
        return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction
    function automatic int ns_down(input int ns);
        return (ns * 1000) / CLK_PERIOD_PS;
    endfunction
    localparam int READ_CYC = ns_up(READ_PERIOD_NS);
    localparam int FLOAT_CYC = ns_up(OUT_DRIVE_FLOAT_NS);
    localparam int STROBE_CYC = ns_up(STROBE_WIDTH_NS);
    localparam int RECOVER_CYC = ns_up(STROBE_HIGH_RECOVERY_NS);
    localparam int HOLD_CYC = ns_up(ADDR_HOLD_NS);
    localparam int LOAD_MIN_CYC = ns_up(BYTE_LOAD_MIN_NS);
    localparam int LOAD_MAX_CYC = ns_down(BYTE_LOAD_MAX_NS);
    localparam int NEXT_WRITE_CYC = ns_up(NEXT_WRITE_DELAY_NS);
    localparam int WRITE_TIME_CYC = INTERNAL_WRITE_TIME_US * 200;
    localparam int CNT_W = 24;
    typedef enum logic [6:0] {
        PEBT_IDLE  = 7'h01,
        PEBT_RD    = 7'h02,
        PEBT_RFLT  = 7'h04,
        PEBT_WLOW  = 7'h08,
        PEBT_WHIGH = 7'h10,
        PEBT_BUSY  = 7'h20,
        PEBT_GAP   = 7'h40
    } pebt_state_t;
endpackage

// *** logic/pebt_tmr_if.sv ***
// interface between controller and its down-counting timer
// assumes one clock domain; load and expiry are same-cycle signals
`timescale 1ns/1ps
interface pebt_tmr_if;
    logic load;
    logic [pebt_pkg::CNT_W-1:0] value;
    logic done;
    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface

// *** logic/pebt_timer.sv ***
// loadable down counter; done is high while the count is zero
// assumes load pulses from logic on the same clock
`timescale 1ns/1ps
module pebt_timer (
    input wire logic core_clk_in, // core clock
    input wire logic sys_rst_in, // async reset, high
    pebt_tmr_if.tmr t // load and expiry
);
    import pebt_pkg::*;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    // next count
    always_comb begin
        cnt_nxt = cnt_r;
        if (t.load) begin
            cnt_nxt = t.value;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end
    // register
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    // expiry depends on the count alone, so the caller may load on it without a loop
    assign t.done = (cnt_r == '0);
endmodule

// *** tb/pebt_host_asserts.sv ***
// checker for the eeprom host pins: strobe modes, read and write spacing
// assumes binding into the controller, one clock domain
`timescale 1ns/1ps
module pebt_host_asserts #(
    parameter int WRITE_WAIT_CYC = pebt_pkg::WRITE_TIME_CYC // max write time
) (
    input wire logic core_clk_in, // clock
    input wire logic sys_rst_in, // reset
    input wire logic busy_out, // busy
    input wire logic [pebt_pkg::ADDR_W-1:0] mem_addr_out, // address
    input wire logic [pebt_pkg::DATA_W-1:0] mem_dq_out, // data out
    input wire logic mem_dq_oe_n_out, // data drive
    input wire logic mem_chip_sel_n_out, // select
    input wire logic mem_out_en_n_out, // read strobe
    input wire logic mem_wr_en_n_out // write strobe
);
    import pebt_pkg::*;
    logic [15:0] hi_r, hi_nxt, rd_r, rd_nxt, fl_r, fl_nxt, gp_r, gp_nxt;
    logic rd_act;
    int bc_r, bc_nxt;
    function automatic logic [15:0] inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction
    assign rd_act = !mem_chip_sel_n_out && !mem_out_en_n_out;
    // cycles: strobe high, read active, since read release, since busy end, busy length
    always_comb begin
        hi_nxt = mem_wr_en_n_out ? inc(hi_r) : 16'h0000;
        rd_nxt = rd_act ? inc(rd_r) : 16'h0000;
        fl_nxt = rd_act ? 16'h0000 : inc(fl_r);
        gp_nxt = busy_out ? 16'h0000 : inc(gp_r);
        bc_nxt = busy_out ? bc_r + 1 : 0;
    end
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {hi_r, rd_r, fl_r, gp_r} <= {16'hffff, 16'h0000, 16'hffff, 16'hffff};
            bc_r <= 0;
        end else begin
            {hi_r, rd_r, fl_r, gp_r} <= {hi_nxt, rd_nxt, fl_nxt, gp_nxt};
            bc_r <= bc_nxt;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_MODE: assert property (!mem_chip_sel_n_out |-> mem_out_en_n_out || mem_wr_en_n_out)
        else $error("read and write strobes low together");
    AST_NO_CONTEND: assert property (!mem_out_en_n_out |-> mem_dq_oe_n_out)
        else $error("host drives data during read strobe");
    AST_RD_ADDR: assert property (rd_act && $past(rd_act) |-> $stable(mem_addr_out))
        else $error("address moved during read");
    AST_RD_LEN: assert property ($fell(rd_act) |-> rd_r >= 16'(READ_CYC))
        else $error("read strobe too short");
    AST_FLOAT: assert property ($fell(mem_dq_oe_n_out) |-> fl_r >= 16'(FLOAT_CYC))
        else $error("data driven before device float");
    AST_WE_RECOVER: assert property ($fell(mem_wr_en_n_out) |-> hi_r >= 16'(RECOVER_CYC))
        else $error("write strobe high too short");
    AST_WR_HOLD: assert property (!mem_wr_en_n_out && $past(!mem_wr_en_n_out)
        |-> $stable({mem_addr_out, mem_dq_out}) && !mem_dq_oe_n_out)
        else $error("write address or data moved");
    AST_BUSY_NO_WR: assert property (busy_out |-> mem_wr_en_n_out)
        else $error("write strobe while busy");
    AST_NEXT_WR: assert property ($fell(mem_wr_en_n_out) |-> gp_r >= 16'(NEXT_WRITE_CYC - 4))
        else $error("write too soon after busy");
    AST_BUSY_LEN: assert property (busy_out |-> bc_r <= WRITE_WAIT_CYC + LOAD_MAX_CYC + 64)
        else $error("busy longer than load window plus write time");
    cover property ($fell(busy_out));
    cover property (busy_out && $fell(rd_act));
    cover property ($fell(mem_wr_en_n_out));
endmodule
bind pebt_host pebt_host_asserts #(.WRITE_WAIT_CYC(WRITE_WAIT_CYC)) u_pebt_host_asserts (
    .core_clk_in, .sys_rst_in, .busy_out, .mem_addr_out, .mem_dq_out, .mem_dq_oe_n_out,
    .mem_chip_sel_n_out, .mem_out_en_n_out, .mem_wr_en_n_out);

// *** tb/pebt_eeprom_model.sv ***
// device model: byte and page loads, self-timed write, polling reads
// assumes the controller pins; times in ns
`timescale 1ns/1ps
module pebt_eeprom_model #(
    parameter real ACC_NS = 118.0, // select and address access
    parameter real OE_NS = 45.0, // output enable access
    parameter real WIN_NS = 1000.0, // load window before programming
    parameter real WR_NS = 1500.0 // internal write, under 5 ms
) (
    input wire logic [pebt_pkg::ADDR_W-1:0] addr_in, // address
    input wire logic cs_n_in, // select
    input wire logic oe_n_in, // read strobe
    input wire logic we_n_in, // write strobe
    input wire logic [pebt_pkg::DATA_W-1:0] host_dq_in, // host data
    input wire logic host_oe_n_in, // host drives when low
    output logic [pebt_pkg::DATA_W-1:0] dq_out, // wire level
    output int viol_out // host timing faults
);
    import pebt_pkg::*;
    logic [7:0] mem [0:8191];
    logic [7:0] q = 8'hff, last_r = 8'hff;
    logic [6:0] pg_r = 7'h00;
    logic vld, rd_seen = 1'b0;
    logic tog = 1'b0; // start level arbitrary
    realtime t_sel = 0, t_oe = 0, t_ld = -1.0e9, t_weh = -1.0e9;
    function automatic bit pend();
        return $realtime - t_ld < WIN_NS + WR_NS;
    endfunction
    initial begin
        viol_out = 0;
        foreach (mem[i]) mem[i] = 8'hff;
    end
    // access clocks and strobe recovery
    always @(negedge cs_n_in or addr_in) t_sel = $realtime;
    always @(negedge oe_n_in) t_oe = $realtime;
    always @(posedge we_n_in) t_weh = $realtime;
    always @(negedge we_n_in) if ($realtime - t_weh < 50.0) viol_out++;
    always @(posedge oe_n_in) if (!cs_n_in && $realtime - t_sel < ACC_NS) viol_out++;
    // polling read flips the toggle bit
    always @(posedge oe_n_in) begin
        if (rd_seen && pend()) tog = ~tog;
        rd_seen = 1'b0;
    end
    // load at strobe release, none while programming
    always @(posedge we_n_in or posedge cs_n_in) begin
        if (we_n_in !== cs_n_in && oe_n_in && !(pend() && $realtime - t_ld >= WIN_NS)) begin
            // same page, spacing, gap after completion
            if (pend() && (addr_in[12:6] != pg_r || $realtime - t_ld < 150.0)) viol_out++;
            if (!pend() && $realtime - t_ld < WIN_NS + WR_NS + 10000.0) viol_out++;
            mem[addr_in] = host_dq_in;
            last_r = host_dq_in;
            pg_r = addr_in[12:6];
            t_ld = $realtime;
        end
    end
    // data after access times, poll pattern while writing
    always #1 begin
        vld = !cs_n_in && !oe_n_in && we_n_in && $realtime - t_sel >= ACC_NS
            && $realtime - t_oe >= OE_NS;
        // a read seen between strobe edges, free of the select release race
        if (!cs_n_in && !oe_n_in && we_n_in) rd_seen = 1'b1;
        if (vld) q = pend() ? {~last_r[7], tog, last_r[5:0]} : mem[addr_in];
        // released wire shows the inverse
        dq_out = !host_oe_n_in ? host_dq_in : vld ? q : ~q;
        if (!host_oe_n_in && !cs_n_in && !oe_n_in) viol_out++;
    end
endmodule

// *** tb/tb_pebt_host.sv ***
// bench: controller against device model and a reference memory
// assumes package widths and timing counts
`timescale 1ns/1ps
module tb_pebt_host;
    import pebt_pkg::*;
    logic core_clk_in, sys_rst_in, cmd_valid_in, cmd_write_in, cmd_last_in, perr, bsy;
    logic cmd_ready_out, rd_valid_out, busy_out, page_err_out, mem_dq_oe_n_out;
    logic mem_chip_sel_n_out, mem_out_en_n_out, mem_wr_en_n_out;
    logic [ADDR_W-1:0] cmd_addr_in, mem_addr_out, a;
    logic [DATA_W-1:0] cmd_wdata_in, rd_data_out, mem_dq_out, mem_dq_in, got;
    logic [DATA_W-1:0] ref_mem [0:8191];
    logic [6:0] pg;
    int errors = 0, total_checks = 0, viol;
    integer seed = 32'hfe45522c;
    pebt_host #(.WRITE_WAIT_CYC(1000)) u_pebt_host (.core_clk_in, .sys_rst_in,
        .cmd_valid_in, .cmd_write_in, .cmd_last_in, .cmd_addr_in, .cmd_wdata_in,
        .cmd_ready_out, .rd_valid_out, .rd_data_out, .busy_out, .page_err_out,
        .mem_addr_out, .mem_chip_sel_n_out, .mem_out_en_n_out, .mem_wr_en_n_out,
        .mem_dq_out, .mem_dq_oe_n_out, .mem_dq_in);
    pebt_eeprom_model u_pebt_eeprom_model (.addr_in(mem_addr_out),
        .cs_n_in(mem_chip_sel_n_out), .oe_n_in(mem_out_en_n_out), .we_n_in(mem_wr_en_n_out),
        .host_dq_in(mem_dq_out), .host_oe_n_in(mem_dq_oe_n_out), .dq_out(mem_dq_in),
        .viol_out(viol));
    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    task automatic fail(input string m);
        errors++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic chk_rd(input logic [12:0] ra);
        total_checks++;
        if (got !== ref_mem[ra]) fail($sformatf("read %h got %h", ra, got));
    endtask
    task automatic chk_err(input logic exp);
        total_checks++;
        if (perr !== exp) fail("page error flag");
    endtask
    task automatic chk_busy(input logic exp);
        total_checks++;
        if (bsy !== exp) fail("busy flag at write end");
    endtask
    // one command held until accepted, outputs sampled at falling edges
    task automatic cmd(input logic w, input logic l, input logic [12:0] ca, input logic [7:0] d);
        int n;
        @(negedge core_clk_in);
        {cmd_valid_in, cmd_write_in, cmd_last_in, cmd_addr_in, cmd_wdata_in} = {1'b1, w, l, ca, d};
        perr = 1'b0;
        n = 0;
        do begin
            @(negedge core_clk_in);
            perr |= page_err_out === 1'b1;
            n++;
        end while (cmd_ready_out !== 1'b1 && n < 6000);
        got = (rd_valid_out === 1'b1) ? rd_data_out : 8'hxx;
        bsy = busy_out;
        cmd_valid_in = 1'b0;
        if (n >= 6000) fail("no ready");
    endtask
    task automatic wr(input logic [12:0] wa, input logic [7:0] d, input logic l, input logic drop);
        cmd(1'b1, l, wa, d);
        chk_err(drop);
        chk_busy(l && !drop);
        if (!drop) ref_mem[wa] = d;
    endtask
    task automatic rd(input logic [12:0] ra);
        cmd(1'b0, 1'b0, ra, 8'h00);
        chk_rd(ra);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {cmd_valid_in, cmd_write_in, cmd_last_in, cmd_addr_in, cmd_wdata_in} = '0;
        sys_rst_in = 1'b1;
        foreach (ref_mem[i]) ref_mem[i] = 8'hff;
        repeat (10) @(negedge core_clk_in);
        sys_rst_in = 1'b0;
        // single byte writes, each read back after polling
        repeat (3) begin
            a = 13'($random(seed));
            wr(a, 8'($random(seed)), 1'b1, 1'b0);
            rd(a);
        end
        $display("test single_write done");
        // four loads in one page
        pg = 7'($random(seed));
        for (int i = 0; i < 4; i++) wr({pg, 6'(i * 9)}, 8'($random(seed)), i == 3, 1'b0);
        for (int i = 0; i < 4; i++) rd({pg, 6'(i * 9)});
        $display("test page_write done");
        // load with foreign page bits is dropped
        wr({pg, 6'h01}, 8'($random(seed)), 1'b0, 1'b0);
        wr({~pg, 6'h02}, 8'($random(seed)), 1'b1, 1'b1);
        wr({pg, 6'h03}, 8'($random(seed)), 1'b1, 1'b0);
        for (int i = 1; i < 4; i++) rd({i == 2 ? ~pg : pg, 6'(i)});
        $display("test page_error done");
        // back-to-back reads at random places
        repeat (4) rd(13'($random(seed)));
        $display("test reads done");
        total_checks++;
        if (viol !== 0) fail("device saw pin timing faults");
        tally_and_finish();
    end
    // run limit well past the expected length
    initial begin
        #400000;
        fail("watchdog");
        tally_and_finish();
    end
endmodule
